//--- include/srack_pkg.sv
package srack_pkg;
  // Register addresses (byte addresses on the 8-bit plain port)
  localparam logic [7:0] ADDR_MODEM_ACK  = 8'h75;
  localparam logic [7:0] ADDR_TX_ACK     = 8'h76;
  localparam logic [7:0] ADDR_RX_ACK     = 8'h77;
  localparam logic [7:0] ADDR_STATUS     = 8'h65;
  localparam logic [7:0] ADDR_CONTROL    = 8'h78;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h79;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h7a;
  localparam logic [7:0] ADDR_VECTOR     = 8'h7b;

  // Reset values
  localparam logic [7:0] ACK_RESET    = 8'h80;
  localparam logic [7:0] VECTOR_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Control register fields
  localparam int CTRL_REG_ACK_EN = 0;
  localparam int CTRL_DAISY_EN   = 1;

  // Interrupt status fields
  localparam int IRQ_ACK_DONE   = 0;
  localparam int IRQ_ACK_EMPTY  = 1;
  localparam int IRQ_ACK_PASSED = 2;
  localparam int IRQ_STACK_OVF  = 3;
  localparam int IRQ_WIDTH      = 4;

  // Context codes
  localparam logic [1:0] CTX_NONE  = 2'h0;
  localparam logic [1:0] CTX_RX    = 2'h1;
  localparam logic [1:0] CTX_TX    = 2'h3;
  localparam logic [1:0] CTX_MODEM = 2'h2;

  // Vector layout: low three bits carry the request code
  localparam logic [2:0] CODE_NONE  = 3'h0;
  localparam logic [2:0] CODE_MODEM = 3'h1;
  localparam logic [2:0] CODE_TX    = 3'h2;
  localparam logic [2:0] CODE_RX    = 3'h3;
  localparam int         CODE_LSB   = 0;
  localparam int         CODE_MSB   = 2;
  localparam int         HIGH_LSB   = 3;
  localparam int         HIGH_MSB   = 7;

  // Context stack
  localparam int STACK_DEPTH = 3;
  localparam logic [1:0] STACK_TOP_IDX = 2'h2;

  typedef enum logic [1:0] {SRACK_MODEM, SRACK_TX, SRACK_RX} srack_class_t;
endpackage

//--- include/srack_stack_if.sv
`timescale 1ns/100ps
interface srack_stack_if;
  logic       push;
  logic       pop;
  logic [1:0] pushCode;
  logic [1:0] topCode;
  logic       overflow;
  modport owner (output push, output pop, output pushCode, input topCode, input overflow);
  modport stack (input push, input pop, input pushCode, output topCode, output overflow);
endinterface

//--- src/service_request_ack_status.sv
// Operation
// - Transmit pair in bits 3:2: shared line then local request.
// - Modem pair in bits 1:0 with the same encoding.
// - Receive pair in bits 5:4: 11 local, 10 external only.
// - Three acknowledge registers at 0x75, 0x76, 0x77, reset value 0x80.
// - Acknowledge registers are read-only; reads return the class vector.
// - Reading an acknowledge register performs an acknowledge cycle for that class.
// - A chained device downstream may claim the acknowledge and supply the vector.
// - The responding device drives the vector onto the data bus.
// - Status bits 7:6 give the current context code.
// - Each acknowledge cycle not passed down the chain pushes a context code onto the stack, unless the stack is full.
// - External bits follow the shared line; internal bits this device's request.
// - Acknowledge with no pending request returns code 000.
`timescale 1ns/100ps
module service_request_ack_status
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Local requests from the channels
  input  wire logic       rx_request_local,
  input  wire logic       tx_request_local,
  input  wire logic       modem_request_local,
  // Shared wire-OR request lines, active low, open drain
  input  wire logic       rxRequestSharedN,
  input  wire logic       txRequestSharedN,
  input  wire logic       modemRequestSharedN,
  output logic            rxRequestSharedOe,
  output logic            txRequestSharedOe,
  output logic            modemRequestSharedOe,
  // Daisy chain
  output logic            ackPassOut,
  output logic      [1:0] ackPassClass,
  input  wire logic       chainVectorValid,
  input  wire logic [7:0] chainVector,
  // Service end and interrupt
  input  wire logic       serviceDone,
  output logic            irq
);
  srack_stack_if st ();

  srack_context_stack u_stack
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .st       (st)
  );

  logic [2:0] sharedMeta;
  logic [2:0] sharedSync;
  logic       rx_request_shared_line;
  logic       tx_request_shared_line;
  logic       modem_request_shared_line;
  logic [7:0] control;
  logic [7:0] vectorBase;
  logic [srack_pkg::IRQ_WIDTH-1:0] irqStatus;
  logic [srack_pkg::IRQ_WIDTH-1:0] irqMask;
  logic [srack_pkg::IRQ_WIDTH-1:0] irqEvent;
  logic [srack_pkg::IRQ_WIDTH-1:0] next_irqStatus;
  logic [7:0] statusByte;
  logic [7:0] next_regRdData;
  logic       register_ack_enable;
  logic       daisyEnable;
  logic       selModem;
  logic       selTx;
  logic       selRx;
  logic       ackRead;
  logic       ackCycle;
  logic       localPending;
  logic       passDown;
  logic       pendingPass;
  logic       passDone;
  logic [2:0] ackCode;
  logic [1:0] ackCtx;
  logic [7:0] ackVector;
  srack_pkg::srack_class_t ackClass;

  function automatic logic [1:0] pairBits(input logic sharedLine, input logic localReq);
    pairBits = {sharedLine, localReq};
  endfunction

  // Shared lines pass two flip-flops
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sharedMeta <= 3'h0;
      sharedSync <= 3'h0;
    end
    else
    begin
      sharedMeta <= {~rxRequestSharedN, ~txRequestSharedN, ~modemRequestSharedN};
      sharedSync <= sharedMeta;
    end
  end

  assign rx_request_shared_line    = sharedSync[2] | rx_request_local;
  assign tx_request_shared_line    = sharedSync[1] | tx_request_local;
  assign modem_request_shared_line = sharedSync[0] | modem_request_local;

  // Own requests pull the shared lines low
  assign rxRequestSharedOe    = rx_request_local;
  assign txRequestSharedOe    = tx_request_local;
  assign modemRequestSharedOe = modem_request_local;

  assign statusByte = {st.topCode,
                       pairBits(rx_request_shared_line, rx_request_local),
                       pairBits(tx_request_shared_line, tx_request_local),
                       pairBits(modem_request_shared_line, modem_request_local)};

  assign register_ack_enable = control[srack_pkg::CTRL_REG_ACK_EN];
  assign daisyEnable         = control[srack_pkg::CTRL_DAISY_EN];

  // Acknowledge decode
  assign selModem = (regAddr == srack_pkg::ADDR_MODEM_ACK);
  assign selTx    = (regAddr == srack_pkg::ADDR_TX_ACK);
  assign selRx    = (regAddr == srack_pkg::ADDR_RX_ACK);
  assign ackRead  = regRead && (selModem || selTx || selRx);
  assign ackCycle = ackRead && register_ack_enable;
  assign ackClass = selModem ? srack_pkg::SRACK_MODEM : (selTx ? srack_pkg::SRACK_TX : srack_pkg::SRACK_RX);

  assign localPending = (ackClass == srack_pkg::SRACK_MODEM) ? modem_request_local :
                        (ackClass == srack_pkg::SRACK_TX) ? tx_request_local : rx_request_local;
  assign ackCode = !localPending ? srack_pkg::CODE_NONE :
                   (ackClass == srack_pkg::SRACK_MODEM) ? srack_pkg::CODE_MODEM :
                   (ackClass == srack_pkg::SRACK_TX) ? srack_pkg::CODE_TX : srack_pkg::CODE_RX;
  assign ackCtx  = (ackClass == srack_pkg::SRACK_MODEM) ? srack_pkg::CTX_MODEM :
                   (ackClass == srack_pkg::SRACK_TX) ? srack_pkg::CTX_TX : srack_pkg::CTX_RX;
  assign ackVector = {vectorBase[srack_pkg::HIGH_MSB:srack_pkg::HIGH_LSB], ackCode};

  // Chained device claims the cycle when this one has nothing and chaining is on
  assign passDown = ackCycle && daisyEnable && !localPending;
  assign passDone = pendingPass && chainVectorValid;

  // Context stack control
  assign st.push     = ackCycle && !passDown;
  assign st.pushCode = localPending ? ackCtx : srack_pkg::CTX_NONE;
  assign st.pop      = serviceDone;

  // Read data mux
  always_comb
  begin
    next_regRdData = srack_pkg::ZERO_BYTE;
    if (passDone)
      next_regRdData = chainVector;
    else if (ackRead && register_ack_enable && !passDown)
      next_regRdData = ackVector;
    else if (ackRead && !register_ack_enable)
      next_regRdData = srack_pkg::ACK_RESET;
    else if (regRead)
    begin
      unique case (regAddr)
        srack_pkg::ADDR_STATUS:     next_regRdData = statusByte;
        srack_pkg::ADDR_CONTROL:    next_regRdData = control;
        srack_pkg::ADDR_IRQ_STATUS: next_regRdData = {4'h0, irqStatus};
        srack_pkg::ADDR_IRQ_MASK:   next_regRdData = {4'h0, irqMask};
        srack_pkg::ADDR_VECTOR:     next_regRdData = vectorBase;
        default:                    next_regRdData = srack_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Interrupt events, set wins over clear
  assign irqEvent = {st.overflow, passDown, ackCycle && !localPending, ackCycle && localPending};
  assign next_irqStatus = (regWrite && regAddr == srack_pkg::ADDR_IRQ_STATUS) ?
                          ((irqStatus & ~regWrData[srack_pkg::IRQ_WIDTH-1:0]) | irqEvent) :
                          (irqStatus | irqEvent);
  assign irq = |(irqStatus & irqMask);

  // Writes to acknowledge addresses fall through and change nothing
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      control     <= srack_pkg::ZERO_BYTE;
      vectorBase  <= srack_pkg::VECTOR_RESET;
      irqMask     <= 4'h0;
      irqStatus   <= 4'h0;
      regRdData   <= srack_pkg::ZERO_BYTE;
      pendingPass <= 1'b0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      regRdData <= next_regRdData;
      if (regWrite && regAddr == srack_pkg::ADDR_CONTROL)
        control <= regWrData;
      if (regWrite && regAddr == srack_pkg::ADDR_VECTOR)
        vectorBase <= regWrData;
      if (regWrite && regAddr == srack_pkg::ADDR_IRQ_MASK)
        irqMask <= regWrData[srack_pkg::IRQ_WIDTH-1:0];
      if (passDown)
        pendingPass <= 1'b1;
      else if (passDone)
        pendingPass <= 1'b0;
    end
  end

  assign ackPassOut   = passDown;
  assign ackPassClass = ackCtx;
endmodule

//--- src/srack_context_stack.sv
`timescale 1ns/100ps
module srack_context_stack
(
  // Clock and reset
  input wire logic    core_clk,
  input wire logic    sys_rst,
  // Stack port
  srack_stack_if.stack st
);
  logic [1:0] entry [srack_pkg::STACK_DEPTH];
  logic [1:0] depth;
  logic       full;
  logic       empty;

  assign full       = (depth == srack_pkg::STACK_TOP_IDX + 2'h1);
  assign empty      = (depth == 2'h0);
  assign st.topCode = empty ? srack_pkg::CTX_NONE : entry[depth - 2'h1];

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      depth       <= 2'h0;
      st.overflow <= 1'b0;
      for (int i = 0; i < srack_pkg::STACK_DEPTH; i++)
        entry[i] <= srack_pkg::CTX_NONE;
    end
    else
    begin
      st.overflow <= st.push && full;
      if (st.push && !full)
      begin
        entry[depth] <= st.pushCode;
        depth        <= depth + 2'h1;
      end
      else if (st.pop && !empty)
        depth <= depth - 2'h1;
    end
  end
endmodule

//--- verif/service_request_ack_status_tb.sv
`timescale 1ns/100ps
module service_request_ack_status_tb;
  logic       core_clk    = 1'b0;
  logic       sys_rst     = 1'b1;
  logic [7:0] regAddr     = 8'h00;
  logic [7:0] regWrData   = 8'h00;
  logic       regWrite    = 1'b0;
  logic       regRead     = 1'b0;
  logic       serviceDone = 1'b0;
  logic       slow        = 1'b0;
  logic [2:0] reqLocal    = 3'h0;
  logic [2:0] extReq      = 3'h0;
  logic [2:0] oe;
  logic [7:0] regRdData, chainVector, a, ev, es;
  logic [1:0] ackPassClass;
  logic [2:0] loc;
  logic       irq, ackPassOut, chainVectorValid;
  wire  [2:0] lineN = ~(oe | extReq);
  int         bad_count = 0;
  int         samples_checked = 0;
  int         n;
  logic [26:0] rows [5] = '{{8'h75, 3'h1, 8'h81, 8'h83}, {8'h76, 3'h2, 8'h82, 8'hcc},
    {8'h77, 3'h4, 8'h83, 8'h70}, {8'h76, 3'h0, 8'h80, 8'h00}, {8'h75, 3'h6, 8'h80, 8'h3c}};
  service_request_ack_status DUT (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rx_request_local(reqLocal[2]), .tx_request_local(reqLocal[1]), .modem_request_local(reqLocal[0]),
    .rxRequestSharedN(lineN[2]), .txRequestSharedN(lineN[1]), .modemRequestSharedN(lineN[0]),
    .rxRequestSharedOe(oe[2]), .txRequestSharedOe(oe[1]), .modemRequestSharedOe(oe[0]),
    .ackPassOut(ackPassOut), .ackPassClass(ackPassClass), .chainVectorValid(chainVectorValid),
    .chainVector(chainVector), .serviceDone(serviceDone), .irq(irq));
  srack_chain_partner chain (.core_clk(core_clk), .sys_rst(sys_rst), .ackPassOut(ackPassOut),
    .ackPassClass(ackPassClass), .slow(slow), .chainVectorValid(chainVectorValid), .chainVector(chainVector));
  initial
    forever #20 core_clk = ~core_clk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= ad;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 cmp(regRdData, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++)
      chk(8'h75 + 8'(i), 8'h80);
    wr(8'h76, 8'h55);
    chk(8'h76, 8'h80);
    chk(8'h65, 8'h00);
    chk(8'h10, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      extReq <= 3'(1 << i);
      repeat (3) @(posedge core_clk);
      chk(8'h65, 8'(8'h02 << (2 * i)));
    end
    extReq <= 3'h0;
    wr(8'h78, 8'h01);
    foreach (rows[i])
    begin
      {a, loc, ev, es} = rows[i];
      reqLocal <= loc;
      repeat (3) @(posedge core_clk);
      chk(a, ev);
      chk(8'h65, es);
      @(posedge core_clk) serviceDone <= 1'b1;
      @(posedge core_clk) serviceDone <= 1'b0;
    end
    reqLocal <= 3'h0;
    #1 cmp({7'h0, irq}, 8'h00);
    wr(8'h7a, 8'h02);
    #1 cmp({7'h0, irq}, 8'h01);
    chk(8'h79, 8'h03);
    wr(8'h79, 8'h02);
    #1 cmp({7'h0, irq}, 8'h00);
    chk(8'h79, 8'h01);
    wr(8'h78, 8'h03);
    for (int s = 0; s < 2; s++)
    begin
      slow <= s[0];
      chk(8'h76, 8'h00);
      for (n = 0; n < 20 && chainVectorValid !== 1'b1; n++)
        @(posedge core_clk) #1;
      if (n == 20)
      begin
        bad_count++;
        wrap_up();
      end
      @(posedge core_clk) #1 cmp(regRdData, 8'h57);
    end
    wr(8'h78, 8'h01);
    wr(8'h79, 8'h0f);
    reqLocal <= 3'h1;
    repeat (4) chk(8'h75, 8'h81);
    chk(8'h79, 8'h09);
    wr(8'h7b, 8'ha8);
    chk(8'h7b, 8'ha8);
    chk(8'h75, 8'ha9);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk(8'h79, 8'h00);
    chk(8'h7b, 8'h80);
    chk(8'h75, 8'h80);
    chk(8'h65, 8'h03);
    wrap_up();
  end
endmodule

//--- verif/srack_ack_monitor.sv
`timescale 1ns/100ps
module srack_ack_monitor
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // Requests
  input wire logic       rx_request_local,
  input wire logic       tx_request_local,
  input wire logic       modem_request_local,
  input wire logic       rxRequestSharedOe,
  input wire logic       txRequestSharedOe,
  input wire logic       modemRequestSharedOe,
  // Chain
  input wire logic       ackPassOut,
  input wire logic [1:0] ackPassClass,
  input wire logic       chainVectorValid,
  input wire logic [7:0] chainVector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic       ackEn;
  wire        isAck    = regAddr inside {8'h75, 8'h76, 8'h77};
  wire        isStat   = regRead && regAddr == 8'h65;
  wire        isModem  = regAddr == 8'h75;
  wire        isTx     = regAddr == 8'h76;
  wire [1:0]  cls      = isModem ? 2'h2 : isTx ? 2'h3 : 2'h1;
  wire [2:0]  code     = isModem ? 3'h1 : isTx ? 3'h2 : 3'h3;
  wire        clsLocal = isModem ? modem_request_local : isTx ? tx_request_local : rx_request_local;
  // Shadow of the acknowledge enable
  always_ff @(posedge core_clk)
    if (sys_rst)
      ackEn <= 1'b0;
    else if (regWrite && regAddr == 8'h78)
      ackEn <= regWrData[0];
  sequence ackRead;
    regRead && isAck && ackEn;
  endsequence
  a_oe_follows_local: assert property ({rxRequestSharedOe, txRequestSharedOe, modemRequestSharedOe} ==
    {rx_request_local, tx_request_local, modem_request_local}) else $error("shared line enable wrong");
  a_read_data_idle: assert property (!$past(regRead) && !$past(chainVectorValid) |-> regRdData == 8'h00)
    else $error("read data outside read");
  a_status_local: assert property (isStat |=> {regRdData[4], regRdData[2], regRdData[0]} ==
    $past({rx_request_local, tx_request_local, modem_request_local})) else $error("status local bits wrong");
  a_status_pairs: assert property (isStat |=> (regRdData[5:0] & ~(regRdData[5:0] >> 1) & 6'h15) == 6'h00)
    else $error("invalid request pair");
  a_ack_code: assert property (ackRead ##0 clsLocal |=> regRdData[2:0] == $past(code))
    else $error("ack code wrong");
  a_ack_empty: assert property (ackRead ##0 (!clsLocal && !ackPassOut) |=> regRdData[2:0] == 3'h0)
    else $error("empty ack code wrong");
  a_plain_read: assert property (regRead && isAck && !ackEn |=> regRdData == 8'h80)
    else $error("plain ack read wrong");
  a_plain_no_pass: assert property (!ackEn |-> !ackPassOut) else $error("pass without enable");
  a_pass_pulse: assert property (ackPassOut |-> ackRead ##0 (!clsLocal && ackPassClass == cls) ##1 !ackPassOut)
    else $error("chain pass wrong");
  a_pass_read_zero: assert property (ackPassOut |=> regRdData == 8'h00)
    else $error("passed ack read not zero");
  a_chain_vector: assert property (chainVectorValid |=> regRdData == $past(chainVector))
    else $error("chain vector not forwarded");
endmodule
bind service_request_ack_status srack_ack_monitor mon (.*);

//--- verif/srack_chain_partner.sv
`timescale 1ns/100ps
module srack_chain_partner
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Acknowledge from upstream
  input  wire logic       ackPassOut,
  input  wire logic [1:0] ackPassClass,
  input  wire logic       slow,
  // Vector answer
  output logic            chainVectorValid,
  output logic      [7:0] chainVector
);
  logic [3:0] waitCount;
  logic       pending;
  logic [1:0] heldClass;
  // Vector lines toggle while not valid
  always_ff @(posedge core_clk)
  begin
    chainVectorValid <= 1'b0;
    chainVector      <= ~chainVector;
    waitCount        <= waitCount - 4'h1;
    if (sys_rst)
    begin
      pending     <= 1'b0;
      chainVector <= 8'h00;
    end
    else if (ackPassOut)
    begin
      pending   <= 1'b1;
      heldClass <= ackPassClass;
      waitCount <= slow ? 4'h6 : 4'h0;
    end
    else if (pending && waitCount == 4'h0)
    begin
      pending          <= 1'b0;
      chainVectorValid <= 1'b1;
      chainVector      <= {6'h15, heldClass};
    end
  end
endmodule
